// ### logic/isb_pkg.sv
// Constants for the two-wire bus status and enable bits block.
// Assumes a 32-bit Avalon-MM slave with byte addresses, one word a register.
package isb_pkg;

  // ----------------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------------
  localparam int          ADDR_W              = 4;
  localparam logic [3:0]  BUS_STATUS_ADDR     = 4'h0;
  localparam logic [3:0]  SERIAL_TIMER_ADDR   = 4'h4;
  localparam logic [7:0]  BUS_STATUS_RESET    = 8'h30;
  localparam logic [7:0]  SERIAL_TIMER_RESET  = 8'h00;
  localparam logic [7:0]  GENERAL_CALL_ADDR   = 8'h00;

  // ----------------------------------------------------------------------
  // Bus status field positions
  // ----------------------------------------------------------------------
  localparam int BUSY_BIT    = 7;
  localparam int IRQ_BIT     = 6;
  localparam int INHIBIT_BIT = 5;
  localparam int RSVD_BIT    = 4;
  localparam int ARB_BIT     = 3;
  localparam int MATCH_BIT   = 2;
  localparam int GCALL_BIT   = 1;
  localparam int ACK_BIT     = 0;

  // Clearable flags, index order: general call, match, arbitration, irq
  localparam int N_FLAGS = 4;
  localparam int FLAG_GCALL = 0;
  localparam int FLAG_MATCH = 1;
  localparam int FLAG_ARB   = 2;
  localparam int FLAG_IRQ   = 3;

  // ----------------------------------------------------------------------
  // Serial/timer control field positions
  // ----------------------------------------------------------------------
  localparam int XBUF_SEL_BIT   = 7;
  localparam int XBUF_RSV_BIT   = 6;
  localparam int RATE_EXT_BIT   = 5;
  localparam int ACCESS_EN_BIT  = 4;
  localparam int PIN_SWITCH_BIT = 3;
  localparam int MULTIPROC_BIT  = 2;
  localparam int TCLK_HI_BIT    = 1;
  localparam int TCLK_LO_BIT    = 0;

endpackage : isb_pkg

// ### logic/isb_top.sv
// Status and condition-control bits of a two-wire serial bus interface,
// plus the shared serial/timer control byte, behind an Avalon-MM slave.
// Assumes bus line samples and unit events are synchronous to clk_in.
//
// Contract
// [R1] Write busy 1, inhibit 0 in master: start
// [R2] Write busy 0, inhibit 0 in master: stop
// [R3] Inhibit reads 1, writes not stored
// [R4] Status bit 4 reads 1, writes ignored
// [R5] Data mismatch in master sets arbitration, irq
// [R6] Master transmit: data disagree at clock rise
// [R7] Master transmit: internal clock high at fall
// [R8] Flags clear by read-as-1 then write 0
// [R9] Flags other than irq clear on data register access
// [R10] Slave receive address or general call match
// [R11] General call address sets general call flag
// [R12] Transmit mode captures receiver acknowledge
// [R13] Receive mode drives software acknowledge value
// [R14] Ack read: captured if transmit, else software
// [R15] Serial/timer control 8-bit, cleared to zero
// [R16] Extra buffer bits store and read back
// [R17] Rate extension joins clock divider select
// [R18] Access enable gates status register access
// [R19] Pass-through bits routed to other units
// [R20] Busy set on start, cleared on stop
// [R21] Status resets to 0x30
// [R22] Write 0 clears only after read as 1
module isb_top (
  // Clock and reset
  input  wire logic                       clk_in,
  input  wire logic                       nrst_in,
  input  wire logic                       standby_in,
  // Avalon-MM slave
  input  wire logic [isb_pkg::ADDR_W-1:0] address_in,
  input  wire logic                       read_in,
  input  wire logic                       write_in,
  input  wire logic [31:0]                writedata_in,
  output logic      [31:0]                readdata_out,
  output logic                            waitrequest_out,
  // Mode from the control, mode and address registers
  input  wire logic                       master_mode_in,
  input  wire logic                       transmit_select_in,
  input  wire logic                       format_select_in,
  input  wire logic [6:0]                 own_slave_address_bits_in,
  input  wire logic [2:0]                 clock_divider_select_in,
  // Bus lines and internal drive levels
  input  wire logic                       scl_in,
  input  wire logic                       sda_in,
  input  wire logic                       internal_scl_in,
  input  wire logic                       internal_sda_in,
  // Transfer events from the shift logic
  input  wire logic                       first_byte_valid_in,
  input  wire logic [7:0]                 first_byte_in,
  input  wire logic                       ack_sample_valid_in,
  input  wire logic                       ack_in,
  input  wire logic                       ack_slot_in,
  input  wire logic                       irq_event_in,
  input  wire logic                       data_write_in,
  input  wire logic                       data_read_in,
  // Condition requests, acknowledge drive and status flags
  output logic                            start_req_out,
  output logic                            stop_req_out,
  output logic                            ack_sda_oe_out,
  output logic                            bus_busy_flag_out,
  output logic                            interrupt_request_flag_out,
  // Serial/timer control outputs
  output logic [3:0]                      rate_select_out,
  output logic                            host_register_access_enable_out,
  output logic                            host_pin_switch_out,
  output logic                            multiprocessor_enable_out,
  output logic [1:0]                      timer_clock_select_out
);

  // ----------------------------------------------------------------------
  // Reset synchroniser
  // ----------------------------------------------------------------------
  logic rst_meta;
  logic rst_n;

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      rst_meta <= 1'b0;
      rst_n    <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n    <= rst_meta;
    end
  end

  // ----------------------------------------------------------------------
  // Avalon slave: one wait cycle, access completes on waitrequest low
  // ----------------------------------------------------------------------
  function automatic logic hit(input logic [isb_pkg::ADDR_W-1:0] a,
                               input logic [isb_pkg::ADDR_W-1:0] b);
    hit = (a == b);
  endfunction

  logic       req;
  logic       access;
  logic       status_sel;
  logic       stc_sel;
  logic [7:0] stc;
  logic       status_open;

  assign req         = read_in | write_in;
  assign access      = req & ~waitrequest_out;
  assign status_open = stc[isb_pkg::ACCESS_EN_BIT];
  // Blocked status register behaves as unmapped
  assign status_sel  = hit(address_in, isb_pkg::BUS_STATUS_ADDR)
                       & status_open; // R18
  assign stc_sel     = hit(address_in, isb_pkg::SERIAL_TIMER_ADDR);

  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      waitrequest_out <= 1'b1;
    end else begin
      waitrequest_out <= ~(req & waitrequest_out);
    end
  end

  logic       st_wr;
  logic       stc_wr;
  logic [7:0] wbyte;

  assign st_wr  = access & write_in & status_sel;
  assign stc_wr = access & write_in & stc_sel;
  assign wbyte  = writedata_in[7:0];

  // ----------------------------------------------------------------------
  // Bus line edge and condition detection
  // ----------------------------------------------------------------------
  logic scl_prev;
  logic sda_prev;
  logic scl_rise;
  logic scl_fall;
  logic start_seen;
  logic stop_seen;
  logic master_tx;

  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      scl_prev <= 1'b1;
      sda_prev <= 1'b1;
    end else begin
      scl_prev <= scl_in;
      sda_prev <= sda_in;
    end
  end

  assign scl_rise   = ~scl_prev & scl_in;
  assign scl_fall   = scl_prev & ~scl_in;
  assign start_seen = scl_prev & scl_in & sda_prev & ~sda_in;
  assign stop_seen  = scl_prev & scl_in & ~sda_prev & sda_in;
  assign master_tx  = master_mode_in & transmit_select_in;

  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      bus_busy_flag_out <= 1'b0;
    end else if (standby_in) begin
      bus_busy_flag_out <= 1'b0;
    end else if (start_seen) begin
      bus_busy_flag_out <= 1'b1; // R20
    end else if (stop_seen) begin
      bus_busy_flag_out <= 1'b0; // R20
    end
  end

  // ----------------------------------------------------------------------
  // Start and stop issue
  // ----------------------------------------------------------------------
  logic issue;

  // A write with the inhibit bit at 1 issues nothing
  assign issue = st_wr & master_mode_in
                 & ~wbyte[isb_pkg::INHIBIT_BIT]; // R3

  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      start_req_out <= 1'b0;
      stop_req_out  <= 1'b0;
    end else begin
      start_req_out <= issue & wbyte[isb_pkg::BUSY_BIT];  // R1
      stop_req_out  <= issue & ~wbyte[isb_pkg::BUSY_BIT]; // R2
    end
  end

  // ----------------------------------------------------------------------
  // Clearable flags
  // ----------------------------------------------------------------------
  localparam int FLAG_POS [isb_pkg::N_FLAGS] = '{
    isb_pkg::GCALL_BIT, isb_pkg::MATCH_BIT,
    isb_pkg::ARB_BIT,   isb_pkg::IRQ_BIT};

  logic [isb_pkg::N_FLAGS-1:0] flag;
  logic [isb_pkg::N_FLAGS-1:0] seen_one;
  logic [isb_pkg::N_FLAGS-1:0] set_ev;
  logic                        arb_lost;
  logic                        slave_rx_fmt;
  logic                        addr_match;
  logic                        gcall_match;
  logic                        data_clear;

  assign arb_lost = master_tx
                    & ((scl_rise & (internal_sda_in != sda_in))  // R6
                    | (scl_fall & internal_scl_in));            // R7
  assign slave_rx_fmt = ~master_mode_in & ~transmit_select_in
                        & ~format_select_in;
  assign gcall_match  = slave_rx_fmt & first_byte_valid_in
                        & (first_byte_in == isb_pkg::GENERAL_CALL_ADDR);
  assign addr_match   = slave_rx_fmt & first_byte_valid_in
                        & (first_byte_in[7:1] == own_slave_address_bits_in);
  // Data register access, the other automatic clear path
  assign data_clear   = (data_write_in & transmit_select_in)
                        | (data_read_in & ~transmit_select_in); // R9

  always_comb begin
    set_ev                     = '0;
    set_ev[isb_pkg::FLAG_GCALL] = gcall_match;              // R11
    set_ev[isb_pkg::FLAG_MATCH] = addr_match | gcall_match; // R10
    set_ev[isb_pkg::FLAG_ARB]   = arb_lost;                 // R5
    set_ev[isb_pkg::FLAG_IRQ]   = arb_lost | addr_match
                                  | gcall_match | irq_event_in; // R5
  end

  for (genvar i = 0; i < isb_pkg::N_FLAGS; i++) begin : g_flag
    logic wr_clear;
    // The irq flag is cleared only by software or standby
    logic auto_clear;
    assign auto_clear = (i != isb_pkg::FLAG_IRQ) & data_clear;
    assign wr_clear   = st_wr & ~wbyte[FLAG_POS[i]] & seen_one[i]; // R22

    always_ff @(posedge clk_in or negedge rst_n) begin
      if (!rst_n) begin
        flag[i] <= 1'b0;
      end else if (standby_in) begin
        flag[i] <= 1'b0;
      end else if (set_ev[i]) begin
        flag[i] <= 1'b1; // Set wins over a write or data-access clear in the same cycle
      end else if (wr_clear | auto_clear) begin
        flag[i] <= 1'b0; // R8 R9
      end
    end

    // Remembers a read that returned 1; a status write consumes it
    always_ff @(posedge clk_in or negedge rst_n) begin
      if (!rst_n) begin
        seen_one[i] <= 1'b0;
      end else if (standby_in | st_wr | ~flag[i]) begin
        seen_one[i] <= 1'b0;
      end else if (access & read_in & status_sel
                   & readdata_out[FLAG_POS[i]]) begin
        seen_one[i] <= 1'b1; // R8
      end
    end
  end

  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      interrupt_request_flag_out <= 1'b0;
    end else begin
      interrupt_request_flag_out <= flag[isb_pkg::FLAG_IRQ];
    end
  end

  // ----------------------------------------------------------------------
  // Acknowledge bit
  // ----------------------------------------------------------------------
  logic ack_sw;
  logic ack_captured;

  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      ack_sw       <= 1'b0;
      ack_captured <= 1'b0;
    end else if (standby_in) begin
      ack_sw       <= 1'b0;
      ack_captured <= 1'b0;
    end else begin
      if (st_wr) begin
        ack_sw <= wbyte[isb_pkg::ACK_BIT];
      end
      if (ack_sample_valid_in & transmit_select_in) begin
        ack_captured <= ack_in; // R12
      end
    end
  end

  // Only ever pulls low; a 1 leaves the line released
  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      ack_sda_oe_out <= 1'b0;
    end else begin
      ack_sda_oe_out <= ack_slot_in & ~transmit_select_in
                        & ~ack_sw & ~standby_in; // R13
    end
  end

  // ----------------------------------------------------------------------
  // Serial/timer control register
  // ----------------------------------------------------------------------
  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      stc <= isb_pkg::SERIAL_TIMER_RESET; // R15
    end else if (standby_in) begin
      stc <= isb_pkg::SERIAL_TIMER_RESET; // R15
    end else if (stc_wr) begin
      stc <= wbyte; // R16
    end
  end

  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      rate_select_out                 <= '0;
      host_register_access_enable_out <= 1'b0;
      host_pin_switch_out             <= 1'b0;
      multiprocessor_enable_out       <= 1'b0;
      timer_clock_select_out          <= '0;
    end else begin
      rate_select_out <= {stc[isb_pkg::RATE_EXT_BIT],
                          clock_divider_select_in}; // R17
      host_register_access_enable_out <= stc[isb_pkg::ACCESS_EN_BIT];
      host_pin_switch_out       <= stc[isb_pkg::PIN_SWITCH_BIT]; // R19
      multiprocessor_enable_out <= stc[isb_pkg::MULTIPROC_BIT];  // R19
      timer_clock_select_out    <= {stc[isb_pkg::TCLK_HI_BIT],
                                    stc[isb_pkg::TCLK_LO_BIT]};  // R19
    end
  end

  // ----------------------------------------------------------------------
  // Read data
  // ----------------------------------------------------------------------
  logic [7:0] status_view;

  always_comb begin
    status_view                       = '0;
    status_view[isb_pkg::BUSY_BIT]    = bus_busy_flag_out;
    status_view[isb_pkg::IRQ_BIT]     = flag[isb_pkg::FLAG_IRQ];
    status_view[isb_pkg::INHIBIT_BIT] = 1'b1; // R3 R21
    status_view[isb_pkg::RSVD_BIT]    = 1'b1; // R4 R21
    status_view[isb_pkg::ARB_BIT]     = flag[isb_pkg::FLAG_ARB];
    status_view[isb_pkg::MATCH_BIT]   = flag[isb_pkg::FLAG_MATCH];
    status_view[isb_pkg::GCALL_BIT]   = flag[isb_pkg::FLAG_GCALL];
    status_view[isb_pkg::ACK_BIT]     = transmit_select_in ? ack_captured
                                                           : ack_sw; // R14
  end

  // Sampled at the first request edge, stands at the completing edge
  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      readdata_out <= '0;
    end else if (req & waitrequest_out) begin
      if (status_sel) begin
        readdata_out <= {24'h00_0000, status_view};
      end else if (stc_sel) begin
        readdata_out <= {24'h00_0000, stc};
      end else begin
        readdata_out <= '0;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_n);

  start_issue_a: assert property ( // R1
    st_wr && master_mode_in && wbyte[7:5] == 3'b100 |=> start_req_out)
    else $error("start not issued");
  stop_issue_a: assert property ( // R2
    st_wr && master_mode_in && wbyte[7:5] == 3'b000 |=> stop_req_out)
    else $error("stop not issued");
  inhibit_block_a: assert property ( // R3
    st_wr && wbyte[isb_pkg::INHIBIT_BIT]
    |=> !start_req_out && !stop_req_out)
    else $error("condition issued with inhibit set");
  status_ones_a: assert property ( // R4
    $past(req && waitrequest_out && status_sel) && !waitrequest_out
    |-> readdata_out[5:4] == 2'b11)
    else $error("fixed status bits not one");
  arb_set_a: assert property ( // R6
    master_tx && scl_rise && internal_sda_in != sda_in
    |=> flag[isb_pkg::FLAG_ARB] && flag[isb_pkg::FLAG_IRQ])
    else $error("arbitration loss not flagged");
  arb_fall_a: assert property ( // R7
    master_tx && scl_fall && internal_scl_in
    |=> flag[isb_pkg::FLAG_ARB])
    else $error("clock arbitration loss not flagged");
  no_blind_clear_a: assert property ( // R22
    flag[isb_pkg::FLAG_ARB] && !seen_one[isb_pkg::FLAG_ARB] && !data_clear
    && !standby_in |=> flag[isb_pkg::FLAG_ARB])
    else $error("flag cleared without prior read");
  gcall_set_a: assert property ( // R11
    gcall_match |=> flag[isb_pkg::FLAG_GCALL] && flag[isb_pkg::FLAG_MATCH])
    else $error("general call not flagged");
  busy_track_a: assert property ( // R20
    start_seen && !standby_in |=> bus_busy_flag_out)
    else $error("busy flag not set on start");
  busy_clear_a: assert property ( // R20
    stop_seen |=> !bus_busy_flag_out)
    else $error("busy flag not cleared on stop");
  ack_drive_a: assert property ( // R13
    ack_slot_in && !transmit_select_in && !ack_sw && !standby_in
    |=> ack_sda_oe_out)
    else $error("acknowledge not driven");
  stc_store_a: assert property ( // R16
    stc_wr && !standby_in |=> stc == $past(wbyte))
    else $error("control byte not stored");

  start_cov: cover property (start_req_out);
  arb_cov:   cover property (arb_lost);
  match_cov: cover property (addr_match);
  clear_cov: cover property (
    seen_one[isb_pkg::FLAG_ARB] ##1 !flag[isb_pkg::FLAG_ARB]);

endmodule // isb_top

// ### dv/isb_bus_peer.sv
// Model of the other masters and slaves sharing the two-wire bus.
// Assumes the bench calls its tasks; lines idle high through pull-ups.
module isb_bus_peer (
  // Clock
  input  wire logic clk_in,
  // Shared bus lines as seen by the block
  output logic      scl_out,
  output logic      sda_out
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    scl_out = 1'b1;
    sda_out = 1'b1;
  end

  task automatic step(input logic c, input logic d);
    @(posedge clk_in);
    scl_out <= c;
    sda_out <= d;
  endtask

  // Data falls while clock high
  task automatic start_cond();
    step(1'b1, 1'b1);
    step(1'b1, 1'b0);
    step(1'b0, 1'b0);
  endtask

  // Data rises while clock high, then both released to the pull-up
  task automatic stop_cond();
    step(1'b0, 1'b0);
    step(1'b1, 1'b0);
    step(1'b1, 1'b1);
  endtask

  // Data only moves while clock is low, so no false conditions
  task automatic clock_bit(input logic d);
    step(1'b0, d);
    step(1'b1, d);
    step(1'b0, d);
  endtask
endmodule // isb_bus_peer

// ### dv/i2c_status_and_enable_bits_test.sv
// Self-checking bench for the bus status and serial/timer control bits.
// Assumes the peer model drives the shared clock and data lines.
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin \
  fail_count++; $display("BAD %0t got %h exp %h", $time, g, e); end end

module i2c_status_and_enable_bits_test;
  timeunit 1ns;
  timeprecision 1ps;

  logic        clk_in = 0, nrst_in = 0, standby_in = 0;
  logic [3:0]  address_in = '0;
  logic        read_in = 0, write_in = 0, waitrequest_out;
  logic [31:0] writedata_in = '0, readdata_out, rd;
  logic        master_mode_in = 0, transmit_select_in = 0;
  logic        format_select_in = 0;
  logic [6:0]  own_slave_address_bits_in = 7'h2a;
  logic [2:0]  clock_divider_select_in = 3'h5;
  logic        scl_in, sda_in, internal_scl_in = 0, internal_sda_in = 1;
  logic        first_byte_valid_in = 0, ack_sample_valid_in = 0;
  logic [7:0]  first_byte_in = '0;
  logic        ack_in = 0, ack_slot_in = 0, irq_event_in = 0;
  logic        data_write_in = 0, data_read_in = 0;
  logic        start_req_out, stop_req_out, ack_sda_oe_out;
  logic        bus_busy_flag_out, interrupt_request_flag_out;
  logic [3:0]  rate_select_out;
  logic        host_register_access_enable_out, host_pin_switch_out;
  logic        multiprocessor_enable_out;
  logic [1:0]  timer_clock_select_out;
  int          fail_count = 0, comparisons = 0, cycles = 0;
  int          starts = 0, stops = 0;

  isb_top dut (.clk_in, .nrst_in, .standby_in, .address_in, .read_in,
    .write_in, .writedata_in, .readdata_out, .waitrequest_out,
    .master_mode_in, .transmit_select_in, .format_select_in,
    .own_slave_address_bits_in, .clock_divider_select_in, .scl_in,
    .sda_in, .internal_scl_in, .internal_sda_in, .first_byte_valid_in,
    .first_byte_in, .ack_sample_valid_in, .ack_in, .ack_slot_in,
    .irq_event_in, .data_write_in, .data_read_in, .start_req_out,
    .stop_req_out, .ack_sda_oe_out, .bus_busy_flag_out,
    .interrupt_request_flag_out, .rate_select_out,
    .host_register_access_enable_out, .host_pin_switch_out,
    .multiprocessor_enable_out, .timer_clock_select_out);

  isb_bus_peer peer (.clk_in, .scl_out(scl_in), .sda_out(sda_in));

  always #5 clk_in = ~clk_in;

  // --------------------------------------------------------------------
  // Pulse counters and hang guard
  // --------------------------------------------------------------------
  always @(posedge clk_in) begin
    starts += start_req_out;
    stops += stop_req_out;
    cycles++;
    if (cycles == 20000) begin
      fail_count++;
      test_done();
    end
  end

  task automatic tick(input int n);
    repeat (n) @(posedge clk_in);
  endtask

  // Avalon-MM access; holds the request until waitrequest is seen low
  task automatic bus(input logic wr, input logic [3:0] a,
                     input logic [7:0] d);
    @(posedge clk_in);
    write_in <= wr;
    read_in <= !wr;
    address_in <= a;
    writedata_in <= {24'h0, d};
    do @(posedge clk_in); while (waitrequest_out !== 1'b0);
    rd = readdata_out;
    write_in <= 1'b0;
    read_in <= 1'b0;
  endtask

  task automatic rchk(input logic [3:0] a, input logic [7:0] e);
    bus(1'b0, a, 8'h00);
    `CHK(rd, {24'h0, e})
  endtask

  task automatic first_byte(input logic [7:0] b);
    @(posedge clk_in);
    first_byte_valid_in <= 1'b1;
    first_byte_in <= b;
    @(posedge clk_in);
    first_byte_valid_in <= 1'b0;
    tick(2);
    bus(1'b0, 4'h0, 8'h00);
  endtask

  task automatic ack_seen(input logic a);
    @(posedge clk_in);
    ack_sample_valid_in <= 1'b1;
    ack_in <= a;
    @(posedge clk_in);
    ack_sample_valid_in <= 1'b0;
    tick(2);
    bus(1'b0, 4'h0, 8'h00);
  endtask

  // --------------------------------------------------------------------
  // Scenarios
  // --------------------------------------------------------------------
  task automatic t_control();
    rchk(4'h0, 8'h00);
    rchk(4'h4, 8'h00);
    bus(1'b1, 4'h4, 8'hef);
    rchk(4'h4, 8'hef);
    tick(2);
    `CHK(rate_select_out, 4'hd)
    `CHK({host_pin_switch_out, multiprocessor_enable_out}, 2'h3)
    `CHK(timer_clock_select_out, 2'h3)
    `CHK(host_register_access_enable_out, 1'b0)
    @(posedge clk_in) standby_in <= 1'b1;
    @(posedge clk_in) standby_in <= 1'b0;
    rchk(4'h4, 8'h00);
    bus(1'b1, 4'h4, 8'h10);
    tick(2);
    `CHK(host_register_access_enable_out, 1'b1)
    $display("test control done");
  endtask

  task automatic t_status();
    rchk(4'h0, 8'h30);
    bus(1'b1, 4'h0, 8'hff);
    rchk(4'h0, 8'h31);
    bus(1'b1, 4'h0, 8'h00);
    rchk(4'h0, 8'h30);
    $display("test status done");
  endtask

  task automatic t_conditions();
    @(posedge clk_in) master_mode_in <= 1'b1;
    bus(1'b1, 4'h0, 8'h80);
    bus(1'b1, 4'h0, 8'h80);
    tick(2);
    `CHK(starts, 2)
    bus(1'b1, 4'h0, 8'ha0);
    bus(1'b1, 4'h0, 8'h20);
    tick(2);
    `CHK(starts + stops, 2)
    bus(1'b1, 4'h0, 8'h00);
    tick(2);
    `CHK(stops, 1)
    @(posedge clk_in) master_mode_in <= 1'b0;
    bus(1'b1, 4'h0, 8'h80);
    tick(2);
    `CHK(starts, 2)
    $display("test conditions done");
  endtask

  task automatic t_busy();
    peer.start_cond();
    tick(3);
    `CHK(bus_busy_flag_out, 1'b1)
    rchk(4'h0, 8'hb0);
    peer.stop_cond();
    tick(3);
    `CHK(bus_busy_flag_out, 1'b0)
    $display("test busy done");
  endtask

  task automatic t_arbitration();
    peer.start_cond();
    @(posedge clk_in);
    master_mode_in <= 1'b1;
    transmit_select_in <= 1'b1;
    peer.clock_bit(1'b0);
    tick(3);
    rchk(4'h0, 8'hf8);
    `CHK(interrupt_request_flag_out, 1'b1)
    bus(1'b1, 4'h0, 8'h76);
    rchk(4'h0, 8'hf0);
    // Irq bit written 1 so only the read memory is consumed
    bus(1'b1, 4'h0, 8'h76);
    bus(1'b1, 4'h0, 8'h36);
    rchk(4'h0, 8'hf0);
    bus(1'b1, 4'h0, 8'h36);
    rchk(4'h0, 8'hb0);
    `CHK(interrupt_request_flag_out, 1'b0)
    @(posedge clk_in);
    internal_sda_in <= 1'b0;
    internal_scl_in <= 1'b1;
    peer.clock_bit(1'b0);
    tick(3);
    rchk(4'h0, 8'hf8);
    @(posedge clk_in) data_write_in <= 1'b1;
    @(posedge clk_in) data_write_in <= 1'b0;
    tick(2);
    rchk(4'h0, 8'hf0);
    bus(1'b1, 4'h0, 8'h36);
    @(posedge clk_in);
    internal_scl_in <= 1'b0;
    master_mode_in <= 1'b0;
    transmit_select_in <= 1'b0;
    peer.stop_cond();
    tick(3);
    rchk(4'h0, 8'h30);
    $display("test arbitration done");
  endtask

  task automatic t_address();
    first_byte(8'h55);
    `CHK(rd[3:0], 4'h4)
    @(posedge clk_in) data_read_in <= 1'b1;
    @(posedge clk_in) data_read_in <= 1'b0;
    tick(2);
    bus(1'b0, 4'h0, 8'h00);
    `CHK(rd[3:0], 4'h0)
    first_byte(8'h00);
    `CHK(rd[3:0], 4'h6)
    bus(1'b1, 4'h0, 8'h30);
    first_byte(8'h57);
    `CHK(rd[3:0], 4'h0)
    @(posedge clk_in) format_select_in <= 1'b1;
    first_byte(8'h55);
    `CHK(rd[3:0], 4'h0)
    @(posedge clk_in) format_select_in <= 1'b0;
    $display("test address done");
  endtask

  task automatic t_ack();
    @(posedge clk_in) transmit_select_in <= 1'b1;
    ack_seen(1'b1);
    `CHK(rd[0], 1'b1)
    ack_seen(1'b0);
    `CHK(rd[0], 1'b0)
    @(posedge clk_in) transmit_select_in <= 1'b0;
    bus(1'b1, 4'h0, 8'h31);
    @(posedge clk_in) ack_slot_in <= 1'b1;
    tick(2);
    `CHK(ack_sda_oe_out, 1'b0)
    bus(1'b1, 4'h0, 8'h30);
    tick(2);
    `CHK(ack_sda_oe_out, 1'b1)
    @(posedge clk_in) ack_slot_in <= 1'b0;
    rchk(4'h0, 8'h30);
    $display("test acknowledge done");
  endtask

  task automatic test_done();
    $display("compares %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  initial begin
    tick(5);
    nrst_in <= 1'b1;
    tick(3);
    t_control();
    t_status();
    t_conditions();
    t_busy();
    t_arbitration();
    t_address();
    t_ack();
    test_done();
  end
endmodule // i2c_status_and_enable_bits_test
